// File: design/mmcl_pkg.sv
// Constants for the memory map control latch
// Function
// - Port fc write captures eight data bits
// - Bits 1:0 pick RAM bank configuration
// - Option 0: ROM reads everywhere, writes top
// - Option 1: ROM in top 8K each 64K
// - Option 2 top 8K of 1M; 3 disables
// - Bit 4 clear forces zero parity writes
// - Bit 5 enables parity checking
package mmcl_pkg;
  localparam logic [7:0]  MEMORY_MAP_CONTROL_PORT = 8'hfc;
  localparam logic [7:0]  MEMORY_MAP_CONTROL_RST  = 8'h00;
  localparam int          BANK_LSB                = 0;
  localparam int          ROM_LSB                 = 2;
  localparam int          ZERO_PARITY_BIT         = 4;
  localparam int          KILL_PARITY_BIT         = 5;
  localparam int          ADDR_W                  = 20;
  localparam logic [19:0] ROM_TOP_BASE            = 20'hfe000;
  localparam logic [15:0] ROM_PAGE_BASE           = 16'he000;

  typedef enum logic [1:0] {
    MMCL_ROM_ALL   = 2'b00,
    MMCL_ROM_PAGE  = 2'b01,
    MMCL_ROM_TOP   = 2'b10,
    MMCL_ROM_OFF   = 2'b11
  } mmcl_rom_place_t;
endpackage

// File: design/mmcl_rom_decode.sv
// Monitor ROM address decoder for one memory access
`timescale 1ns/10ps
module mmcl_rom_decode (
  input  wire logic                       mem_wr,
  input  wire logic [mmcl_pkg::ADDR_W-1:0] mem_addr,
  input  wire mmcl_pkg::mmcl_rom_place_t  place,
  output logic                            rom_hit
);
  import mmcl_pkg::*;

  logic top_hit;
  logic page_hit;

  assign top_hit  = (mem_addr[19:13] == ROM_TOP_BASE[19:13]);
  assign page_hit = (mem_addr[15:13] == ROM_PAGE_BASE[15:13]);

  always_comb begin
    case (place)
      // Writes behave as in top-of-megabyte placement
      MMCL_ROM_ALL:  rom_hit = mem_wr ? top_hit : 1'b1;
      MMCL_ROM_PAGE: rom_hit = page_hit;
      MMCL_ROM_TOP:  rom_hit = top_hit;
      MMCL_ROM_OFF:  rom_hit = 1'b0;
      default:       rom_hit = 1'b0;
    endcase
  end
endmodule

// File: design/mmcl_top.sv
// Memory map control latch and derived memory controls
`timescale 1ns/10ps
module mmcl_top #(
  parameter int LATCH_W     = 8,
  parameter int PORT_ADDR_W = 8
) (
  input  wire logic                        clk,
  input  wire logic                        rstn,
  input  wire logic                        io_wr,
  input  wire logic [PORT_ADDR_W-1:0]      io_addr,
  input  wire logic [LATCH_W-1:0]          io_wdata,
  input  wire logic                        mem_req,
  input  wire logic                        mem_wr,
  input  wire logic [mmcl_pkg::ADDR_W-1:0] mem_addr,
  input  wire logic                        parity_gen,
  output logic [1:0]                       ram_bank_config,
  output logic                             rom_select,
  output logic                             parity_store,
  output logic                             parity_check_en,
  output logic [LATCH_W-1:0]               memory_map_control
);
  import mmcl_pkg::*;

  // Reset and port images at the configured widths
  localparam logic [LATCH_W-1:0]     RST_VAL  =
    LATCH_W'(MEMORY_MAP_CONTROL_RST);
  localparam logic [PORT_ADDR_W-1:0] PORT_VAL =
    PORT_ADDR_W'(MEMORY_MAP_CONTROL_PORT);

  // Bank configuration codes, one to four
  localparam logic [1:0] CFG_ONE   = 2'h0;
  localparam logic [1:0] CFG_TWO   = 2'h1;
  localparam logic [1:0] CFG_THREE = 2'h2;
  localparam logic [1:0] CFG_FOUR  = 2'h3;

  // Refuse sizes the field layout cannot serve
  if (LATCH_W < KILL_PARITY_BIT + 1) begin : g_chk_latch_w
    $error("mmcl_top: LATCH_W too narrow for the control fields");
  end

  if (PORT_ADDR_W < 8) begin : g_chk_port_w
    $error("mmcl_top: PORT_ADDR_W too narrow for the latch port");
  end

  if (ADDR_W != 20) begin : g_chk_addr_w
    $error("mmcl_top: ROM windows assume a 20-bit address");
  end

  if (BANK_LSB + 1 >= ROM_LSB ||
      ROM_LSB + 1 >= ZERO_PARITY_BIT) begin : g_chk_fields
    $error("mmcl_top: control fields overlap");
  end

  if (ZERO_PARITY_BIT >= KILL_PARITY_BIT) begin : g_chk_parity
    $error("mmcl_top: parity bits out of order");
  end

  if (ROM_PAGE_BASE[12:0] != 13'h0000) begin : g_chk_page
    $error("mmcl_top: page window must align to 8K");
  end

  if (ROM_TOP_BASE[12:0] != 13'h0000) begin : g_chk_top
    $error("mmcl_top: top window must align to 8K");
  end

  // Latch storage and its fields
  logic [LATCH_W-1:0] ctl_q;
  logic               port_match;
  logic               wr_hit;
  logic [1:0]         bank_sel;
  mmcl_rom_place_t    place;
  logic               parity_keep;
  logic               check_on;

  // Access qualifiers and decoder result
  logic               acc_rd;
  logic               acc_wr;
  logic               acc_any;
  logic               rom_hit;

  // Next values of the registered outputs
  logic [1:0]         ram_bank_config_d;
  logic               parity_check_en_d;
  logic [LATCH_W-1:0] memory_map_control_d;
  logic               rom_select_d;
  logic               parity_store_d;

  // Port decode; writes to other ports leave no trace
  assign port_match = (io_addr == PORT_VAL);
  assign wr_hit     = io_wr && port_match;

  // One flip-flop per latch bit, loaded by a matching write
  for (genvar i = 0; i < LATCH_W; i++) begin : g_latch
    always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
        ctl_q[i] <= RST_VAL[i];
      end else if (wr_hit) begin
        ctl_q[i] <= io_wdata[i];
      end
    end
  end

  // Field split; bits 7:6 reach only the image
  assign bank_sel    = ctl_q[BANK_LSB+1:BANK_LSB];
  assign place       = mmcl_rom_place_t'(ctl_q[ROM_LSB+1:ROM_LSB]);
  assign parity_keep = ctl_q[ZERO_PARITY_BIT];
  assign check_on    = ctl_q[KILL_PARITY_BIT];

  // Accesses count only while a request stands
  assign acc_rd  = mem_req && !mem_wr;
  assign acc_wr  = mem_req && mem_wr;
  assign acc_any = acc_rd || acc_wr;

  // Decoder splits reads from writes under option 0
  mmcl_rom_decode u_dec (
    .mem_wr   (mem_wr),
    .mem_addr (mem_addr),
    .place    (place),
    .rom_hit  (rom_hit)
  );

  // Bank configuration, spelled out per code
  always_comb begin
    case (bank_sel)
      2'h0:    ram_bank_config_d = CFG_ONE;
      2'h1:    ram_bank_config_d = CFG_TWO;
      2'h2:    ram_bank_config_d = CFG_THREE;
      2'h3:    ram_bank_config_d = CFG_FOUR;
      default: ram_bank_config_d = CFG_ONE;
    endcase
  end

  // Parity checking runs only with bit 5 set
  always_comb begin
    if (check_on) begin
      parity_check_en_d = 1'b1;
    end else begin
      parity_check_en_d = 1'b0;
    end
  end

  // Whole latch image, ignored top bits included
  always_comb begin
    memory_map_control_d = ctl_q;
  end

  // ROM select per placement; idle cycles select nothing
  always_comb begin
    rom_select_d = 1'b0;
    case (place)
      MMCL_ROM_ALL: begin
        rom_select_d = acc_any && rom_hit;
      end
      MMCL_ROM_PAGE: begin
        rom_select_d = acc_any && rom_hit;
      end
      MMCL_ROM_TOP: begin
        rom_select_d = acc_any && rom_hit;
      end
      MMCL_ROM_OFF: begin
        rom_select_d = 1'b0;
      end
      default: begin
        rom_select_d = 1'b0;
      end
    endcase
  end

  // A cleared bit 4 stores zero parity on every write
  always_comb begin
    parity_store_d = 1'b0;
    if (acc_wr && parity_keep) begin
      parity_store_d = parity_gen;
    end else if (acc_wr) begin
      parity_store_d = 1'b0;
    end
  end

  // Outputs trail the latch by one edge, so each
  // leaves straight from a flip-flop
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ram_bank_config <= 2'h0;
    end else begin
      ram_bank_config <= ram_bank_config_d;
    end
  end

  // Checking gate
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      parity_check_en <= 1'b0;
    end else begin
      parity_check_en <= parity_check_en_d;
    end
  end

  // Image copied bit by bit
  for (genvar j = 0; j < LATCH_W; j++) begin : g_image
    always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
        memory_map_control[j] <= 1'b0;
      end else begin
        memory_map_control[j] <= memory_map_control_d[j];
      end
    end
  end

  // Access outputs hold for one cycle per request and use
  // the latch as it stood when the request was sampled
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rom_select <= 1'b0;
    end else begin
      rom_select <= rom_select_d;
    end
  end

  // Parity bit for the write sampled at this edge
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      parity_store <= 1'b0;
    end else begin
      parity_store <= parity_store_d;
    end
  end
endmodule

// File: tb/mmcl_host.sv
// Host model writing the I/O port
`timescale 1ns/10ps
module mmcl_host (
  input  wire logic  clk,
  output logic       io_wr,
  output logic [7:0] io_addr,
  output logic [7:0] io_wdata
);
  initial {io_wr, io_addr, io_wdata} = '0;
  task automatic wr(logic [7:0] a, d);
    {io_wr, io_addr, io_wdata} <= {1'h1, a, d};
    @(posedge clk) {io_wr, io_wdata} <= {1'h0, ~d};
  endtask
endmodule

// File: tb/mmcl_properties.sv
// Checker for the memory map control latch
`timescale 1ns/10ps
module mmcl_properties (
  input wire logic        clk,
  input wire logic        rstn,
  input wire logic        io_wr,
  input wire logic        mem_req,
  input wire logic        mem_wr,
  input wire logic        parity_gen,
  input wire logic        rom_select,
  input wire logic        parity_store,
  input wire logic        parity_check_en,
  input wire logic [1:0]  ram_bank_config,
  input wire logic [7:0]  io_addr,
  input wire logic [7:0]  io_wdata,
  input wire logic [7:0]  memory_map_control,
  input wire logic [19:0] mem_addr
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  logic            wr_q;
  always_ff @(posedge clk) wr_q <= io_wr;
  wire logic [7:0] m = memory_map_control;
  // Output copy lags the latch, so judge only settled accesses
  wire logic       c = mem_req && !io_wr && !wr_q;
  a_latch_wr: assert property (io_wr && io_addr == 8'hfc |-> ##2
    m == $past(io_wdata, 2)) else $error("latch");
  a_cfg_copy: assert property (
    {parity_check_en, ram_bank_config} == {m[5], m[1:0]})
    else $error("config");
  a_rom_page: assert property (c && m[3:2] == 2'h1 |=>
    rom_select == &$past(mem_addr[15:13])) else $error("rom");
  a_par_zero: assert property (c && mem_wr |=>
    parity_store == $past(parity_gen && m[4])) else $error("parity");
  a_rom_top: assert property (c && m[3:2] == 2'h2 |=>
    rom_select == &$past(mem_addr[19:13])) else $error("rom top");
  a_rom_off: assert property (c && m[3:2] == 2'h3 |=>
    !rom_select) else $error("rom off");
  a_rom_read: assert property (c && !mem_wr && m[3:2] == 2'h0 |=>
    rom_select) else $error("rom read");
  a_idle_quiet: assert property (!mem_req |=>
    !rom_select && !parity_store) else $error("idle");
endmodule
bind mmcl_top mmcl_properties i_chk (
  .clk                (clk),
  .rstn               (rstn),
  .io_wr              (io_wr),
  .mem_req            (mem_req),
  .mem_wr             (mem_wr),
  .parity_gen         (parity_gen),
  .rom_select         (rom_select),
  .parity_store       (parity_store),
  .parity_check_en    (parity_check_en),
  .ram_bank_config    (ram_bank_config),
  .io_addr            (io_addr),
  .io_wdata           (io_wdata),
  .memory_map_control (memory_map_control),
  .mem_addr           (mem_addr)
);

// File: tb/tb_top.sv
// Bench for the memory map control latch
`timescale 1ns/10ps
module tb_top;
  logic        clk = 1'h0;
  logic        rstn = 1'h0;
  logic        io_wr;
  logic        mem_req;
  logic        mem_wr;
  logic        parity_gen;
  logic        rom_select;
  logic        parity_store;
  logic        parity_check_en;
  logic        acc_seen = 1'h0;
  logic [1:0]  ram_bank_config;
  logic [1:0]  seen = 2'h0;
  logic [1:0]  e_acc;
  logic [1:0]  acc_q[$];
  logic [7:0]  io_addr;
  logic [7:0]  io_wdata;
  logic [7:0]  memory_map_control;
  logic [7:0]  lat = 8'h00;
  logic [7:0]  exp_q[$];
  logic [19:0] mem_addr;
  logic [16:0] r;
  logic [22:0] a;
  int          err_count = 0;
  int          n_checks = 0;
  mmcl_top i_dut (
    .clk                (clk),
    .rstn               (rstn),
    .io_wr              (io_wr),
    .io_addr            (io_addr),
    .io_wdata           (io_wdata),
    .mem_req            (mem_req),
    .mem_wr             (mem_wr),
    .mem_addr           (mem_addr),
    .parity_gen         (parity_gen),
    .ram_bank_config    (ram_bank_config),
    .rom_select         (rom_select),
    .parity_store       (parity_store),
    .parity_check_en    (parity_check_en),
    .memory_map_control (memory_map_control)
  );
  mmcl_host i_host (
    .clk      (clk),
    .io_wr    (io_wr),
    .io_addr  (io_addr),
    .io_wdata (io_wdata)
  );
  initial forever #12.5 clk = ~clk;
  task give_verdict;
    if (err_count == 0 && n_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic cmp_latch(input logic [7:0] e);
    n_checks++;
    if (e !== memory_map_control) begin
      err_count++;
      $display("ERROR %0t latch image", $time);
    end
  endtask
  task automatic cmp_cfg(input logic [7:0] e);
    n_checks++;
    if ({e[5], e[1:0]} !== {parity_check_en, ram_bank_config}) begin
      err_count++;
      $display("ERROR %0t bank or parity check", $time);
    end
  endtask
  task automatic cmp_acc(input logic [1:0] e);
    n_checks++;
    if (e !== {rom_select, parity_store}) begin
      err_count++;
      $display("ERROR %0t access outputs", $time);
    end
  endtask
  // ROM hit per placement, from the latch value in use
  function automatic logic rom_exp(input logic [7:0] l, input logic w,
                                   input logic [19:0] ad);
    case (l[3:2])
      2'h0:    rom_exp = w ? &ad[19:13] : 1'h1;
      2'h1:    rom_exp = &ad[15:13];
      2'h2:    rom_exp = &ad[19:13];
      default: rom_exp = 1'h0;
    endcase
  endfunction
  always @(posedge clk) begin : watch
    logic [7:0] e;
    seen     <= {seen[0], io_wr && io_addr == 8'hfc};
    acc_seen <= mem_req;
    if (seen[1]) begin
      e = exp_q.pop_front();
      cmp_latch(e);
      cmp_cfg(e);
    end
    if (acc_seen) cmp_acc(acc_q.pop_front());
    else if (rstn) cmp_acc(2'h0);
  end
  initial begin
    #100000 err_count++;
    give_verdict;
  end
  initial begin
    {mem_req, mem_wr, parity_gen, mem_addr} = '0;
    void'($urandom(77467));
    repeat (16) @(posedge clk);
    rstn <= 1'h1;
    repeat (400) begin
      @(posedge clk);
      r = 17'($urandom);
      if (r[16] || r[15:8] == 8'hfc) begin
        lat = r[7:0];
        exp_q.push_back(r[7:0]);
      end
      i_host.wr(r[16] ? 8'hfc : r[15:8], r[7:0]);
      repeat (r[1:0]) begin
        @(posedge clk);
        a = 23'($urandom);
        {mem_req, mem_wr, parity_gen, mem_addr} <= a;
        e_acc = {rom_exp(lat, a[21], a[19:0]), a[21] && a[20] && lat[4]};
        if (a[22]) acc_q.push_back(e_acc);
      end
      @(posedge clk);
      mem_req <= 1'h0;
    end
    repeat (3) @(posedge clk);
    give_verdict;
  end
endmodule
